/* dac_load_pkg.sv */
/*
  Constants shared by the serial DAC load front end.
  Assumes a single system clock; all pins are asynchronous to it.
*/
// Behaviour
// - Frame select low: shift data in MSB first on falling serial clock edges.
// - Twelve-bit variant takes code from word bits 13 to 2.
// - Fourteen-bit variant takes code from word bits 13 to 0.
// - DAC register code is unsigned straight binary.
// - Load strobe sampled at frame select fall picks sync or async update.
// - Sampled strobe low: load DAC register at frame select rise.
// - Sampled strobe high: no load at frame end; strobe low loads later.
// - Without readback, input bits reach serial output sixteen clocks later.
// - Serial output changes on the falling serial clock edge.
// - Serial output is open drain: pulls low or releases.
// - Readback enable active: serial output carries DAC register contents.
// - Clear falling edge forces output code to clear level.
// - Clear leaves shift register and DAC register unchanged.
// - Device is powered down while power-down input is asserted.
// - Readback enable low: DAC register copied to shift register next clock.
// - Readback word is sixteen bits with two top bits zero.
// - Power-down entry or exit keeps DAC register contents.
// - Clear release reloads output, automatically or on next low strobe.
`default_nettype none
package dac_load_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 14;
  localparam int CODE_MSB = 13;
  localparam int NARROW_LSB = 2;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_ZERO = 14'h0000;
  localparam logic [CODE_W-1:0] CLEAR_CODE = 14'h0000;
endpackage
`default_nettype wire

/* dac_load_sva.sv */
/* Checker for the serial DAC load front end.
   Sees only the top ports; bound to every instance. */
`timescale 1ns/100ps
`default_nettype none
module dac_load_sva
  import dac_load_pkg::*;
#(
  parameter bit WIDE = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic frame_sync_n,
  input wire logic load_strobe_n,
  input wire logic readback_enable_n,
  input wire logic clear_output_n,
  input wire logic power_down_n,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe,
  input wire logic [CODE_W-1:0] dac_code,
  input wire logic [CODE_W-1:0] output_code,
  input wire logic output_at_ground_ref,
  input wire logic powered_down
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Serial output pin behaviour
  a_od_low: assert property (serial_data_out_o == 1'b0)
    else $error("open drain value high");
  a_oe_after_fall: assert property ($changed(serial_data_out_oe)
    |-> !$past(serial_clk)) else $error("output moved off clock fall");
  // Power-down follows its pin
  a_pd_enter: assert property ($fell(power_down_n)
    |-> ##[2:5] powered_down) else $error("no power-down");
  a_pd_leave: assert property ($rose(power_down_n)
    |-> ##[2:5] !powered_down) else $error("power-down stuck");
  // Clear level and code tracking
  a_clr_forces: assert property ($fell(clear_output_n)
    |-> ##[2:6] output_at_ground_ref && output_code == CLEAR_CODE)
    else $error("clear not applied");
  a_clr_holds: assert property (output_at_ground_ref [*2]
    |-> output_code == CLEAR_CODE) else $error("code left clear level");
  a_code_tracks: assert property ((!output_at_ground_ref) [*4]
    |-> output_code == dac_code) else $error("code not tracking");
  a_narrow_top: assert property ((WIDE == 1'b0)
    |-> dac_code[13:12] == 2'b00) else $error("narrow top bits set");
endmodule
bind serial_dac_load_interface dac_load_sva #(.WIDE(WIDE)) u_sva (
  .sys_clk(sys_clk), .rst_b(rst_b), .serial_clk(serial_clk),
  .serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n),
  .load_strobe_n(load_strobe_n), .readback_enable_n(readback_enable_n),
  .clear_output_n(clear_output_n), .power_down_n(power_down_n),
  .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe(serial_data_out_oe), .dac_code(dac_code),
  .output_code(output_code), .output_at_ground_ref(output_at_ground_ref),
  .powered_down(powered_down));
`default_nettype wire

/* host_model.sv */
/* Host serial master: frames words onto the link.
   Assumes a pulled-up open-drain return line. */
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  input wire logic sdo_line,
  output logic serial_clk,
  output logic serial_data_in,
  output logic frame_sync_n
);
  logic [16:0] cap;
  // Idle link: clock parked high, frame released
  initial begin
    serial_clk = 1'b1;
    serial_data_in = 1'b0;
    frame_sync_n = 1'b1;
  end
  task automatic half;
    repeat (4) @(negedge sys_clk);
  endtask
  // Frame of n falls, MSB first; return line taken on each rise
  task automatic xfer(input logic [15:0] w, input int n, input bit fr);
    frame_sync_n = !fr;
    for (int i = 0; i < n; i++) begin
      serial_data_in = fr ? w[15-i] : !serial_data_in;
      half;
      serial_clk = 1'b0;
      half;
      serial_clk = 1'b1;
      cap = {cap[15:0], sdo_line};
    end
    half;
    frame_sync_n = 1'b1;
    serial_data_in = !serial_data_in;
    half;
  endtask
endmodule
`default_nettype wire

/* pin_sync.sv */
/*
  Two-stage synchroniser bank for asynchronous pins.
  Assumes the destination clock is sys_clk; reset value is a parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pins_async,
  output logic [W-1:0] pins_sync
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= INIT;
      pins_sync <= INIT;
    end else begin
      meta_q <= pins_async;
      pins_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* serial_dac_load_interface.sv */
/*
  Serial DAC load interface: shift register, DAC register, update control,
  daisy-chain and readback output, clear and power-down.
  Assumes all pins are asynchronous to sys_clk and the serial clock is slow
  enough (many sys_clk periods per phase) to be edge-detected.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_dac_load_interface
  import dac_load_pkg::*;
#(
  parameter bit WIDE = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic frame_sync_n,
  input wire logic load_strobe_n,
  input wire logic readback_enable_n,
  input wire logic clear_output_n,
  input wire logic power_down_n,
  output logic serial_data_out_o,
  output logic serial_data_out_oe,
  output logic [CODE_W-1:0] dac_code,
  output logic [CODE_W-1:0] output_code,
  output logic output_at_ground_ref,
  output logic powered_down
);
  localparam int NPIN = 7;
  localparam logic [NPIN-1:0] PIN_INIT = 7'h7F;

  // Frame progress as seen from the link pins
  typedef enum logic [1:0] {
    LINK_IDLE,
    LINK_SHIFT,
    LINK_FULL,
    LINK_OVER
  } link_state_t;

  // Power state follows the power-down pin
  typedef enum logic {
    PWR_ACTIVE,
    PWR_DOWN
  } power_state_t;

  logic [NPIN-1:0] pins_s;
  logic sclk_s, serial_data_in_s, sync_s, load_strobe_n_s, readback_enable_n_s, clr_s, pd_s;
  logic sclk_prev_q, sync_prev_q, clr_prev_q, readback_enable_n_prev_q;
  logic sclk_fall, sync_fall, sync_rise, clr_fall, clr_rise;
  logic [WORD_W-1:0] shift_q;
  logic [CODE_W-1:0] dac_q;
  logic [CODE_W-1:0] word_code;
  logic async_mode_q;
  logic word_full_q;
  logic [4:0] bit_cnt_q;
  logic readback_pend_q;
  logic clear_q;
  logic readback_enable_n_fall;
  logic word_done;
  logic sdo_d;
  logic [WORD_W-1:0] shift_d;
  logic [CODE_W-1:0] code_d;
  link_state_t link_q, link_d;
  power_state_t pwr_q, pwr_d;
  logic sdo_q;

  // Pin synchronisers
  pin_sync #(.W(NPIN), .INIT(PIN_INIT)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pins_async({serial_clk, serial_data_in, frame_sync_n, load_strobe_n,
                 readback_enable_n, clear_output_n, power_down_n}),
    .pins_sync(pins_s)
  );
  assign {sclk_s, serial_data_in_s, sync_s, load_strobe_n_s, readback_enable_n_s, clr_s, pd_s} = pins_s;

  // Edge history of synchronised pins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_q <= 1'b1;
      sync_prev_q <= 1'b1;
      clr_prev_q <= 1'b1;
      readback_enable_n_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      sync_prev_q <= sync_s;
      clr_prev_q <= clr_s;
      readback_enable_n_prev_q <= readback_enable_n_s;
    end
  end

  assign sclk_fall = sclk_prev_q & ~sclk_s;
  assign sync_fall = sync_prev_q & ~sync_s;
  assign sync_rise = ~sync_prev_q & sync_s;
  assign clr_fall = clr_prev_q & ~clr_s;
  assign clr_rise = ~clr_prev_q & clr_s;
  assign readback_enable_n_fall = readback_enable_n_prev_q & ~readback_enable_n_s;

  // Code field extraction per variant
  always_comb begin
    if (WIDE) begin
      word_code = shift_q[CODE_MSB:0];
    end else begin
      word_code = {2'b00, shift_q[CODE_MSB:NARROW_LSB]};
    end
  end

  // Shift register next value, one slice per bit position
  genvar gi;
  generate
    for (gi = 0; gi < WORD_W; gi++) begin : g_shift
      if (gi == 0) begin : g_lsb
        assign shift_d[gi] = serial_data_in_s;
      end else begin : g_upper
        assign shift_d[gi] = shift_q[gi-1];
      end
    end
  endgenerate

  // Frame tracker: a word counts as done once sixteen bits are in
  always_comb begin
    link_d = link_q;
    case (link_q)
      LINK_IDLE: begin
        if (sync_fall) begin
          link_d = LINK_SHIFT;
        end
      end
      LINK_SHIFT: begin
        if (sync_rise) begin
          link_d = LINK_IDLE; // Short frame, nothing to load later
        end else if (word_full_q) begin
          link_d = LINK_FULL;
        end
      end
      LINK_FULL: begin
        if (sync_fall) begin
          link_d = LINK_SHIFT;
        end else if (sclk_fall && !sync_s) begin
          link_d = LINK_OVER; // Extra clock inside the frame
        end
      end
      LINK_OVER: begin
        if (sync_fall) begin
          link_d = LINK_SHIFT;
        end
      end
      default: begin
        link_d = LINK_IDLE;
      end
    endcase
  end

  // Frame tracker state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_q <= LINK_IDLE;
    end else begin
      link_q <= link_d;
    end
  end

  // Later strobe may load once a whole word has arrived
  assign word_done = (link_q == LINK_FULL) || (link_q == LINK_OVER);

  // Readback request: held until the next falling serial clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readback_pend_q <= 1'b0;
    end else if (readback_enable_n_fall) begin
      readback_pend_q <= 1'b1;
    end else if (sclk_fall) begin
      readback_pend_q <= 1'b0;
    end
  end

  // Shift register: shifts in frame, or loads DAC data for readback
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= WORD_ZERO;
    end else if (sclk_fall && readback_pend_q) begin
      shift_q <= {2'b00, dac_q};
    end else if (sclk_fall && (!sync_s || !readback_enable_n_s)) begin
      shift_q <= shift_d;
    end
  end

  // Bit counter: a full word needs sixteen falling edges
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q <= 5'h00;
      word_full_q <= 1'b0;
    end else if (sync_fall) begin
      bit_cnt_q <= 5'h00;
      word_full_q <= 1'b0;
    end else if (sclk_fall && !sync_s && !word_full_q) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      word_full_q <= (bit_cnt_q == 5'(WORD_W - 1));
    end
  end

  // Update mode sampled at frame start
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      async_mode_q <= 1'b0;
    end else if (sync_fall) begin
      async_mode_q <= load_strobe_n_s;
    end
  end

  // DAC register load; clear and power-down never touch it
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_q <= CODE_ZERO;
    end else if (sync_rise && !async_mode_q) begin
      dac_q <= word_code;
    end else if (async_mode_q && word_done && sync_s && !load_strobe_n_s) begin
      dac_q <= word_code;
    end
  end

  // Pending output update after clear release without a strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clear_q <= 1'b0;
    end else begin
      if (clr_fall) begin
        clear_q <= 1'b1;
      end else if (clr_rise && !load_strobe_n_s) begin
        clear_q <= 1'b0;
      end else if (clear_q && clr_s && !load_strobe_n_s) begin
        clear_q <= 1'b0;
      end
    end
  end

  // Output code next value; clear level wins while clear is low
  always_comb begin
    if (clear_q || !clr_s) begin
      code_d = CLEAR_CODE;
    end else begin
      code_d = dac_q;
    end
  end

  // Output code register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_code <= CODE_ZERO;
    end else begin
      output_code <= code_d;
    end
  end

  // Serial output next bit: zero on readback load, else shifted-out MSB
  always_comb begin
    if (readback_pend_q) begin
      sdo_d = 1'b0;
    end else begin
      sdo_d = shift_q[WORD_W-1];
    end
  end

  // Serial output moves only on a falling serial clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sdo_q <= 1'b1;
    end else if (sclk_fall) begin
      sdo_q <= sdo_d;
    end
  end

  // Open drain: drive low only, otherwise release
  assign serial_data_out_o = 1'b0;
  assign serial_data_out_oe = ~sdo_q;

  // Power state next value; the DAC register is never touched here
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      PWR_ACTIVE: begin
        if (!pd_s) begin
          pwr_d = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (pd_s) begin
          pwr_d = PWR_ACTIVE;
        end
      end
      default: begin
        pwr_d = PWR_ACTIVE;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_q <= PWR_ACTIVE;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign powered_down = (pwr_q == PWR_DOWN);

  // Status outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_at_ground_ref <= 1'b0;
      dac_code <= CODE_ZERO;
    end else begin
      output_at_ground_ref <= clear_q | ~clr_s;
      dac_code <= dac_q;
    end
  end
endmodule
`default_nettype wire

/* tb.sv */
/* Self-checking bench for the serial DAC load front end.
   Host model drives the link; both widths share the pins. */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dac_load_pkg::*;
  logic sys_clk = 0, rst_b = 0, load_strobe_n = 0, readback_enable_n = 1;
  logic clear_output_n = 1, power_down_n = 1, oe, pd_q, gnd_q;
  logic serial_clk, serial_data_in, frame_sync_n;
  logic [CODE_W-1:0] dac, dac_n, out_code;
  logic [15:0] w, prev;
  int n_errors = 0, n_compared = 0, m_dac = 0;
  always #20 sys_clk = ~sys_clk;
  // Link master with pull-up on the return line
  host_model u_host_model (.sys_clk(sys_clk), .sdo_line(!oe),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .frame_sync_n(frame_sync_n));
  serial_dac_load_interface u_serial_dac_load_interface (.sys_clk(sys_clk),
    .rst_b(rst_b), .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .frame_sync_n(frame_sync_n), .load_strobe_n(load_strobe_n),
    .readback_enable_n(readback_enable_n), .clear_output_n(clear_output_n),
    .power_down_n(power_down_n), .serial_data_out_o(),
    .serial_data_out_oe(oe), .dac_code(dac), .output_code(out_code),
    .output_at_ground_ref(gnd_q), .powered_down(pd_q));
  serial_dac_load_interface #(.WIDE(1'b0)) u_serial_dac_load_interface_n (
    .sys_clk(sys_clk), .rst_b(rst_b), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .frame_sync_n(frame_sync_n),
    .load_strobe_n(load_strobe_n), .readback_enable_n(readback_enable_n),
    .clear_output_n(clear_output_n), .power_down_n(power_down_n),
    .serial_data_out_o(), .serial_data_out_oe(), .dac_code(dac_n),
    .output_code(), .output_at_ground_ref(), .powered_down());
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wt;
    repeat (8) @(negedge sys_clk);
  endtask
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    complete_run;
  end
  // Frames alternating sync and async update, then readback
  initial begin
    void'($urandom(32'h9B06));
    repeat (10) @(negedge sys_clk);
    rst_b = 1;
    wt;
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom);
      load_strobe_n = i[0];
      u_host_model.xfer(w, 16, 1'b1);
      if (i > 0) chk(u_host_model.cap[15:0], prev);
      if (i[0]) begin
        wt;
        chk(dac, 16'(m_dac));
        load_strobe_n = 0;
      end
      m_dac = w[13:0];
      wt;
      chk(dac, 16'(m_dac));
      chk(dac_n, {4'h0, w[13:2]});
      chk(out_code, 16'(m_dac));
      prev = w;
    end
    load_strobe_n = 1;
    readback_enable_n = 0;
    u_host_model.xfer(w, 17, 1'b0);
    readback_enable_n = 1;
    chk(u_host_model.cap[15:0], 16'(m_dac));
    // Clear held across a synchronous load
    clear_output_n = 0;
    wt;
    chk(out_code, 16'h0);
    chk(gnd_q, 16'h1);
    chk(dac, 16'(m_dac));
    w = 16'($urandom);
    load_strobe_n = 0;
    u_host_model.xfer(w, 16, 1'b1);
    m_dac = w[13:0];
    wt;
    chk(out_code, 16'h0);
    chk(dac, 16'(m_dac));
    clear_output_n = 1;
    wt;
    chk(out_code, 16'(m_dac));
    chk(gnd_q, 16'h0);
    // Power-down round trip
    power_down_n = 0;
    wt;
    chk(pd_q, 16'h1);
    power_down_n = 1;
    wt;
    chk(pd_q, 16'h0);
    chk(dac, 16'(m_dac));
    complete_run;
  end
endmodule
`default_nettype wire
